// ==== src/rtcc_top.sv ====
/*
 Calendar real-time counter: BCD calendar, wait/acknowledge access,
 alarm match, fixed-cycle events and drift correction.
 Assumes fsub_in is a 32.768 kHz level synchronous to clk.
*/
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rtcc_top
  import rtcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        fsub_in,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             calendar_interrupt,
  output logic             one_hertz_output_pin,
  output logic             raw_clock_output_pin
);
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        wr_ok;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        rd_ok;
  logic [7:0]  ctrl_r;
  logic [7:0]  corr_r;
  logic [7:0]  alarm_minute_r;
  logic [7:0]  alarm_hour_r;
  logic [7:0]  alarm_weekday_mask_r;
  logic        wait_status_r;
  logic        fixed_cycle_flag_r;
  logic        alarm_detect_flag_r;
  logic        fsub_r;
  logic        tick;
  logic [7:0]  cal_r [CAL_NUM];
  logic [7:0]  snap_r [CAL_NUM];
  logic [7:0]  cal_nxt [CAL_NUM];
  logic [3:0]  roll;
  logic        cal_we;
  logic [2:0]  cal_idx;
  logic [15:0] subsec;
  logic        sec_pulse;
  logic        half;
  logic        apply;
  logic        cyc_evt;
  logic        alm_match;
  logic        alm_match_r;
  logic        alm_evt;
  logic        run;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    unique case (m)
      8'h02: month_last = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  endfunction : month_last

  function automatic logic is_cal(input logic [7:0] a);
    is_cal = a >= OFS_CAL0 && a < OFS_CORR;
  endfunction : is_cal

  rtcc_axil u_axil (
    .clk           (clk),
    .rst_b         (rst_b),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_ok         (wr_ok),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  assign run     = ctrl_r[CTL_RUN] && ctrl_r[CTL_FEED];
  assign tick    = fsub_in && !fsub_r && ctrl_r[CTL_FEED];
  assign cal_idx = 3'(wr_addr[4:2] - OFS_CAL0[4:2]);
  // Calendar writes only land while the access wait is acknowledged
  assign cal_we  = wr_en && is_cal(wr_addr) && wait_status_r;
  assign wr_ok   = is_cal(wr_addr) || wr_addr == OFS_CTRL || wr_addr == OFS_STAT
                || (wr_addr >= OFS_CORR && wr_addr <= OFS_ALM_WDAY);
  assign apply   = corr_r[CORR_DEV] ? (cal_r[CAL_SEC] == ZERO8)
                 : (cal_r[CAL_SEC] == ZERO8 || cal_r[CAL_SEC] == BCD_20
                    || cal_r[CAL_SEC] == BCD_40);

  rtcc_subsec u_subsec (
    .clk         (clk),
    .rst_b       (rst_b),
    .tick        (tick),
    .run         (run),
    .clr         (cal_we && cal_idx == CAL_SEC),
    .apply       (apply),
    .corr        (corr_r),
    .count_r     (subsec),
    .sec_pulse_r (sec_pulse),
    .half_r      (half)
  );

  // Calendar carry chain
  always_comb begin
    for (int i = 0; i < CAL_NUM; i++) begin
      cal_nxt[i] = cal_r[i];
    end
    roll = 4'h0;
    if (sec_pulse) begin
      cal_nxt[CAL_SEC] = bcd_inc(cal_r[CAL_SEC]);
      if (cal_r[CAL_SEC] == BCD_59) begin
        cal_nxt[CAL_SEC] = ZERO8;
        roll[0] = 1'b1;
        cal_nxt[CAL_MIN] = bcd_inc(cal_r[CAL_MIN]);
        if (cal_r[CAL_MIN] == BCD_59) begin
          cal_nxt[CAL_MIN] = ZERO8;
          roll[1] = 1'b1;
          cal_nxt[CAL_HOUR] = bcd_inc(cal_r[CAL_HOUR]);
          if (cal_r[CAL_HOUR] == BCD_23) begin
            cal_nxt[CAL_HOUR] = ZERO8;
            roll[2] = 1'b1;
            cal_nxt[CAL_WEEK] = (cal_r[CAL_WEEK] == WEEK_LAST) ? ZERO8
                              : bcd_inc(cal_r[CAL_WEEK]);
            cal_nxt[CAL_DAY] = bcd_inc(cal_r[CAL_DAY]);
            if (cal_r[CAL_DAY] == month_last(cal_r[CAL_MONTH], cal_r[CAL_YEAR])) begin
              cal_nxt[CAL_DAY] = DAY_RST;
              roll[3] = 1'b1;
              cal_nxt[CAL_MONTH] = bcd_inc(cal_r[CAL_MONTH]);
              if (cal_r[CAL_MONTH] == BCD_12) begin
                cal_nxt[CAL_MONTH] = MONTH_RST;
                cal_nxt[CAL_YEAR] = (cal_r[CAL_YEAR] == BCD_99) ? ZERO8
                                  : bcd_inc(cal_r[CAL_YEAR]);
              end
            end
          end
        end
      end
    end
  end

  // Live counters keep running; a written field replaces its next value
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < CAL_NUM; i++) begin
        cal_r[i] <= ZERO8;
      end
      cal_r[CAL_DAY]   <= DAY_RST;
      cal_r[CAL_MONTH] <= MONTH_RST;
    end else begin
      for (int i = 0; i < CAL_NUM; i++) begin
        cal_r[i] <= (cal_we && cal_idx == 3'(i)) ? wr_data : cal_nxt[i];
      end
    end
  end

  // Frozen view for software while the wait is acknowledged
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < CAL_NUM; i++) begin
        snap_r[i] <= ZERO8;
      end
    end else begin
      for (int i = 0; i < CAL_NUM; i++) begin
        if (!wait_status_r) begin
          snap_r[i] <= cal_r[i];
        end else if (cal_we && cal_idx == 3'(i)) begin
          snap_r[i] <= wr_data;
        end
      end
    end
  end

  // Wait acknowledge follows the request on a subsystem tick, or every cycle while run is low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wait_status_r <= 1'b0;
    end else if (tick || !run) begin
      wait_status_r <= ctrl_r[CTL_WAIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r               <= CTRL_RST;
      corr_r               <= CORR_RST;
      alarm_minute_r       <= ALM_MIN_RST;
      alarm_hour_r         <= ALM_HOUR_RST;
      alarm_weekday_mask_r <= ALM_WDAY_RST;
    end else if (wr_en) begin
      unique case (wr_addr)
        OFS_CTRL:     ctrl_r               <= wr_data;
        OFS_CORR:     corr_r               <= wr_data;
        OFS_ALM_MIN:  alarm_minute_r       <= wr_data;
        OFS_ALM_HOUR: alarm_hour_r         <= wr_data;
        OFS_ALM_WDAY: alarm_weekday_mask_r <= wr_data;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (ctrl_r[CTL_CYC_LSB +: 3])
      CYC_SEC:   cyc_evt = sec_pulse;
      CYC_MIN:   cyc_evt = roll[0];
      CYC_HOUR:  cyc_evt = roll[1];
      CYC_DAY:   cyc_evt = roll[2];
      CYC_MONTH: cyc_evt = roll[3];
      default:   cyc_evt = 1'b0;
    endcase
  end

  assign alm_match = cal_r[CAL_MIN] == alarm_minute_r && cal_r[CAL_HOUR] == alarm_hour_r
                  && alarm_weekday_mask_r[cal_r[CAL_WEEK][2:0]];
  assign alm_evt   = ctrl_r[CTL_ALM_EN] && alm_match && !alm_match_r;

  // Flags: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fixed_cycle_flag_r  <= 1'b0;
      alarm_detect_flag_r <= 1'b0;
      alm_match_r         <= 1'b0;
      calendar_interrupt  <= 1'b0;
    end else begin
      alm_match_r        <= alm_match;
      calendar_interrupt <= cyc_evt || alm_evt;
      if (cyc_evt) begin
        fixed_cycle_flag_r <= 1'b1;
      end else if (wr_en && wr_addr == OFS_STAT && wr_data[ST_CYC]) begin
        fixed_cycle_flag_r <= 1'b0;
      end
      if (alm_evt) begin
        alarm_detect_flag_r <= 1'b1;
      end else if (wr_en && wr_addr == OFS_STAT && wr_data[ST_ALM]) begin
        alarm_detect_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fsub_r               <= 1'b0;
      raw_clock_output_pin <= 1'b0;
      one_hertz_output_pin <= 1'b0;
    end else begin
      fsub_r               <= fsub_in;
      raw_clock_output_pin <= fsub_in && ctrl_r[CTL_FEED];
      one_hertz_output_pin <= half;
    end
  end

  // Any calendar field readable in any order
  always_comb begin
    rd_ok   = 1'b1;
    rd_data = ZERO8;
    if (is_cal(rd_addr)) begin
      rd_data = wait_status_r ? snap_r[3'(rd_addr[4:2] - OFS_CAL0[4:2])]
                              : cal_r[3'(rd_addr[4:2] - OFS_CAL0[4:2])];
    end else begin
      unique case (rd_addr)
        OFS_CTRL:     rd_data = ctrl_r;
        OFS_STAT:     rd_data = {5'h00, alarm_detect_flag_r, fixed_cycle_flag_r,
                                 wait_status_r};
        OFS_CORR:     rd_data = corr_r;
        OFS_ALM_MIN:  rd_data = alarm_minute_r;
        OFS_ALM_HOUR: rd_data = alarm_hour_r;
        OFS_ALM_WDAY: rd_data = alarm_weekday_mask_r;
        OFS_SUBSEC:   rd_data = subsec[7:0];
        default:      rd_ok   = 1'b0;
      endcase
    end
  end
endmodule : rtcc_top

// ==== pkg/rtcc_pkg.sv ====
/*
 Constants for the calendar counter: register map, field positions,
 reset values and correction figures.
 Assumes a 32-bit AXI4-Lite register bus and a 50 MHz system clock.
*/
package rtcc_pkg;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STAT      = 8'h04;
  localparam logic [7:0]  OFS_CAL0      = 8'h08;
  localparam logic [7:0]  OFS_CORR      = 8'h24;
  localparam logic [7:0]  OFS_ALM_MIN   = 8'h28;
  localparam logic [7:0]  OFS_ALM_HOUR  = 8'h2C;
  localparam logic [7:0]  OFS_ALM_WDAY  = 8'h30;
  localparam logic [7:0]  OFS_SUBSEC    = 8'h34;
  localparam int          CAL_NUM       = 7;
  localparam logic [2:0]  CAL_SEC       = 3'h0;
  localparam logic [2:0]  CAL_MIN       = 3'h1;
  localparam logic [2:0]  CAL_HOUR      = 3'h2;
  localparam logic [2:0]  CAL_WEEK      = 3'h3;
  localparam logic [2:0]  CAL_DAY       = 3'h4;
  localparam logic [2:0]  CAL_MONTH     = 3'h5;
  localparam logic [2:0]  CAL_YEAR      = 3'h6;
  // Control bits
  localparam int          CTL_RUN       = 0;
  localparam int          CTL_FEED      = 1;
  localparam int          CTL_ALM_EN    = 2;
  localparam int          CTL_WAIT      = 3;
  localparam int          CTL_CYC_LSB   = 4;
  // Status bits
  localparam int          ST_WAIT       = 0;
  localparam int          ST_CYC        = 1;
  localparam int          ST_ALM        = 2;
  // Correction fields
  localparam int          CORR_DEV      = 7;
  localparam int          CORR_SIGN     = 6;
  localparam logic [15:0] SUB_REF       = 16'h7FFF;
  localparam logic [15:0] SUB_HALF      = 16'h3FFF;
  // Fixed-cycle select codes
  localparam logic [2:0]  CYC_OFF       = 3'h0;
  localparam logic [2:0]  CYC_SEC       = 3'h1;
  localparam logic [2:0]  CYC_MIN       = 3'h2;
  localparam logic [2:0]  CYC_HOUR      = 3'h3;
  localparam logic [2:0]  CYC_DAY       = 3'h4;
  localparam logic [2:0]  CYC_MONTH     = 3'h5;
  // Reset values
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  CORR_RST      = 8'h00;
  localparam logic [7:0]  ALM_MIN_RST   = 8'h00;
  localparam logic [7:0]  ALM_HOUR_RST  = 8'h12;
  localparam logic [7:0]  ALM_WDAY_RST  = 8'h00;
  localparam logic [7:0]  DAY_RST       = 8'h01;
  localparam logic [7:0]  MONTH_RST     = 8'h01;
  localparam logic [7:0]  ZERO8         = 8'h00;
  // BCD limits and correction seconds
  localparam logic [7:0]  BCD_59        = 8'h59;
  localparam logic [7:0]  BCD_23        = 8'h23;
  localparam logic [7:0]  BCD_20        = 8'h20;
  localparam logic [7:0]  BCD_40        = 8'h40;
  localparam logic [7:0]  BCD_12        = 8'h12;
  localparam logic [7:0]  BCD_99        = 8'h99;
  localparam logic [7:0]  WEEK_LAST     = 8'h06;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : rtcc_pkg

// ==== src/rtcc_axil.sv ====
/*
 AXI4-Lite slave front end: takes address and data in either order,
 gives one write strobe and a registered read capture.
 Assumes the parent decodes addresses combinationally.
*/
`timescale 1ns/1ps
module rtcc_axil
  import rtcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  input  wire logic        wr_ok,
  output logic [7:0]       rd_addr,
  input  wire logic [7:0]  rd_data,
  input  wire logic        rd_ok
);
  logic       aw_r;
  logic       w_r;
  logic [7:0] awaddr_r;
  logic [7:0] wdata_r;
  logic       wlane_r;

  assign s_axi_awready = !aw_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_en         = aw_r && w_r && wlane_r;
  assign wr_addr       = awaddr_r;
  assign wr_data       = wdata_r;
  assign rd_addr       = s_axi_araddr;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_r         <= 1'b0;
      w_r          <= 1'b0;
      awaddr_r     <= ZERO8;
      wdata_r      <= ZERO8;
      wlane_r      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r     <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r     <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (aw_r && w_r) begin
        aw_r         <= 1'b0;
        w_r          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_data};
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : rtcc_axil

// ==== src/rtcc_subsec.sv ====
/*
 Sub-second counter with drift correction of its overflow threshold.
 Assumes one-cycle subsystem clock ticks and a correction apply level
 from the parent that is high during the selected seconds.
*/
`timescale 1ns/1ps
module rtcc_subsec
  import rtcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic        clr,
  input  wire logic        apply,
  input  wire logic [7:0]  corr,
  output logic [15:0]      count_r,
  output logic             sec_pulse_r,
  output logic             half_r
);
  logic [5:0]  mag;
  logic [15:0] thr;

  assign mag = corr[5:0];

  always_comb begin
    thr = SUB_REF;
    if (apply && mag != 6'h00) begin
      if (!corr[CORR_SIGN]) begin
        thr = SUB_REF + {9'h000, mag - 6'h01, 1'b0};
      end else begin
        thr = SUB_REF - {9'h000, ~mag + 6'h01, 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_r     <= 16'h0000;
      sec_pulse_r <= 1'b0;
    end else begin
      sec_pulse_r <= 1'b0;
      if (clr || !run) begin
        count_r <= 16'h0000;
      end else if (tick) begin
        if (count_r >= thr) begin
          count_r     <= 16'h0000;
          sec_pulse_r <= 1'b1;
        end else begin
          count_r <= count_r + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      half_r <= 1'b0;
    end else begin
      half_r <= run && (count_r <= SUB_HALF);
    end
  end
endmodule : rtcc_subsec

// ==== tb/rtcc_checker.sv ====
/*
 Checker for rtcc_top: bus answer timing, answer dropping after acceptance, interrupt pulse.
 Assumes it is bound into rtcc_top and sees only its ports.
*/
`timescale 1ns/1ps
module rtcc_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        fsub_in,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        calendar_interrupt,
  input wire logic        raw_clock_output_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read not answered next cycle");
  chk_rd_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read answer repeated");
  chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("Read upper bits not zero");
  chk_ar_block: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
    else $error("Read answered without a request");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("Write not answered");
  chk_wr_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write answer repeated");
  chk_aw_block: assert property ($rose(s_axi_bvalid) |->
    $past(!s_axi_awready && !s_axi_wready)) else $error("Write answered before both taken");
  chk_irq_pulse: assert property (calendar_interrupt |=> !calendar_interrupt)
    else $error("Interrupt longer than one cycle");
  chk_raw_copy: assert property (raw_clock_output_pin |-> $past(fsub_in))
    else $error("Raw clock pin not a copy of the tick");
endmodule : rtcc_checker

bind rtcc_top rtcc_checker u_chk (.clk(clk), .rst_b(rst_b), .fsub_in(fsub_in),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .calendar_interrupt(calendar_interrupt),
  .raw_clock_output_pin(raw_clock_output_pin));

// ==== tb/tb_rtc_access_alarm_correction.sv ====
/*
 Testbench for rtcc_top: register access, wait hold, alarm, drift correction.
 Assumes a 50 MHz clock; the subsystem tick is sped up to one every 2 clocks.
*/
`timescale 1ns/1ps
module tb_rtc_access_alarm_correction
  import rtcc_pkg::*;
;
  logic        clk, rst_b, fsub_in, awv, awr, wv, wr, bv, arv, arr, rv, irq, hz, raw;
  logic [7:0]  awa, ara, c;
  logic [5:0]  mg;
  logic [31:0] wd, rd, v;
  logic [1:0]  bp, rp;
  logic [65:0] qr[$];
  logic [1:0]  qb[$];
  int          num_errors, checked, irqs, n, dl;
  logic [7:0]  ra[5] = '{OFS_CTRL, OFS_CORR, OFS_ALM_HOUR, 8'h18, 8'h1C};
  logic [7:0]  rs[5] = '{CTRL_RST, CORR_RST, ALM_HOUR_RST, DAY_RST, MONTH_RST};
  logic [7:0]  tv[7] = '{8'h00, 8'h45, 8'h21, 8'h03, 8'h28, 8'h02, 8'h24};

  rtcc_top dut (.clk(clk), .rst_b(rst_b), .fsub_in(fsub_in), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bp), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rp), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .calendar_interrupt(irq), .one_hertz_output_pin(hz), .raw_clock_output_pin(raw));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) fsub_in <= ~fsub_in;

  function automatic logic [7:0] cal_a(int i);
    return OFS_CAL0 + 8'(4 * i);
  endfunction : cal_a

  task automatic cmp(logic [33:0] g, logic [33:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic guard(logic ok);
    if (!ok) begin
      num_errors++;
      $display("Error %0t: wait bound used up", $time);
      complete_run();
    end
  endtask : guard

  // Answers are sampled at the falling edge, one response per cycle
  always @(negedge clk) begin
    if (rv && qr.size() > 0) begin
      cmp({rp, rd & qr[0][63:32]}, {qr[0][65:64], qr[0][31:0]});
      void'(qr.pop_front());
    end
    if (bv && qb.size() > 0) begin
      cmp(34'(bp), 34'(qb[0]));
      void'(qb.pop_front());
    end
    if (irq)
      irqs++;
  end

  task automatic rd_reg(logic [7:0] a, logic [7:0] d, logic [31:0] m = 32'hFFFFFFFF,
                        logic [1:0] x = RESP_OKAY);
    logic ha, hb;
    int   k;
    qr.push_back({x, m, 24'h000000, d});
    ara <= a;
    arv <= 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      ha = arv && arr;
      hb = rv;
      v = rd;
      @(posedge clk);
      if (ha)
        arv <= 1'b0;
      k++;
    end while (!hb && k < 40);
    guard(hb);
  endtask : rd_reg

  task automatic wr_reg(logic [7:0] a, logic [7:0] d, logic [1:0] x = RESP_OKAY);
    logic ha, hw, hb;
    int   k;
    qb.push_back(x);
    awa <= a;
    wd <= {24'($urandom), d};
    awv <= 1'b1;
    wv <= 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      ha = awv && awr;
      hw = wv && wr;
      hb = bv;
      @(posedge clk);
      if (ha)
        awv <= 1'b0;
      if (hw)
        wv <= 1'b0;
      k++;
    end while (!hb && k < 40);
    guard(hb);
  endtask : wr_reg

  task automatic poll(logic w);
    int k;
    k = 0;
    do begin
      rd_reg(OFS_STAT, 8'h00, 32'h0);
      k++;
    end while (v[ST_WAIT] !== w && k < 100);
    guard(v[ST_WAIT] === w);
  endtask : poll

  initial begin
    {fsub_in, rst_b, awv, wv, arv} = '0;
    {awa, ara, wd} = '0;
    void'($urandom(32'h46A0AF64));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
      rd_reg(ra[i], rs[i]);
    rd_reg(8'hFC, 8'h00, 32'hFFFFFFFF, RESP_SLVERR);
    wr_reg(8'hFC, 8'h5A, RESP_SLVERR);
    wr_reg(OFS_ALM_MIN, 8'h45);
    wr_reg(OFS_ALM_HOUR, 8'h21);
    wr_reg(OFS_ALM_WDAY, 8'h08);
    // Feed, alarm enable, wait request
    wr_reg(OFS_CTRL, 8'h0E);
    poll(1'b1);
    // Raw pin is the tick level one clock late
    @(negedge clk);
    cmp(34'(raw), 34'(!fsub_in));
    @(posedge clk);
    for (int i = 6; i >= 0; i--)
      wr_reg(cal_a(i), tv[i]);
    for (int i = 0; i < 7; i++)
      rd_reg(cal_a((i * 3) % 7), tv[(i * 3) % 7]);
    rd_reg(OFS_STAT, 8'h05);
    cmp(34'(irqs), 34'h1);
    wr_reg(OFS_STAT, 8'h04);
    rd_reg(OFS_STAT, 8'h01);
    c = 8'($urandom);
    wr_reg(OFS_CORR, c);
    rd_reg(OFS_CORR, c);
    mg = ~c[5:0];
    if (c[5:0] == 6'h00)
      dl = 0;
    else if (c[CORR_SIGN])
      dl = -2 * (int'(mg) + 1);
    else
      dl = 2 * (int'(c[5:0]) - 1);
    // Run, feed, fixed cycle each second
    wr_reg(OFS_CTRL, 8'h13);
    repeat (4) @(posedge clk);
    poll(1'b0);
    for (n = 0; n < 40000 && hz !== 1'b0; n++)
      @(negedge clk);
    guard(hz === 1'b0);
    for (n = 0; n < 40000 && hz !== 1'b1; n++)
      @(negedge clk);
    cmp(34'(n), 34'(2 * (int'(SUB_REF - SUB_HALF) + dl)));
    @(posedge clk);
    for (n = 0; n < 20 && v[ST_CYC] !== 1'b1; n++)
      rd_reg(OFS_STAT, 8'h00, 32'h0);
    cmp(34'(v[7:0]), 34'h02);
    cmp(34'(irqs), 34'h2);
    wr_reg(OFS_CTRL, 8'h1B);
    poll(1'b1);
    rd_reg(cal_a(CAL_SEC), 8'h01);
    rd_reg(cal_a(CAL_MIN), 8'h45);
    wr_reg(OFS_CTRL, 8'h13);
    poll(1'b0);
    complete_run();
  end
endmodule : tb_rtc_access_alarm_correction
